/* File: src/function_pin_port_router.v */
// Function-pin decoder and router for the 32-bit parallel port.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "port_router_defines.vh"

module function_pin_port_router (
    input  wire        clock,
    input  wire        reset,
    input  wire [3:0]  function_select,
    input  wire [31:0] port_in,
    output reg  [31:0] port_out,
    output reg  [31:0] port_oe,
    input  wire        io_update,
    input  wire        serial_data_out,
    input  wire        serial_data_out_oe,
    input  wire        ser_data_io_out,
    input  wire        ser_data_io_oe,
    output reg         ser_chip_select_n,
    output reg         ser_clock,
    output reg         ser_data_io_in,
    output reg         serial_port_resync,
    output reg  [31:0] core_frequency,
    output reg  [15:0] core_phase,
    output reg  [11:0] core_amplitude,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [31:0] reg_rdata
);

    // ****************************************************************
    // State
    // ****************************************************************
    reg  [31:0] control_one_r, control_two_r, freq_hold_r, freq_active_r;
    reg  [15:0] phase_hold_r, amp_hold_r, phase_active_r, amp_active_r;
    reg  [4:0]  sample_count_r;
    reg         prev_write_r;
    reg  [31:0] control_one_nxt, control_two_nxt, freq_hold_nxt, merge_word;
    reg  [15:0] phase_hold_nxt, amp_hold_nxt;
    reg  [31:0] wr_data, port_out_nxt, port_oe_nxt, par_word;
    reg  [3:0]  wr_be;
    reg  [5:0]  wr_index;
    reg         wr_en;
    wire        sample_now, direct_mode, par_mode, ser_mode;
    wire        par_write, par_read, par_wide;
    wire [5:0]  par_index;
    wire [1:0]  par_lane;
    wire        stream_en, match_en, osk_en;
    wire [31:0] freq_short, freq_long;
    wire [15:0] phase_short, phase_long, amp_long;

    assign par_mode    = (function_select == `FUNC_PARALLEL);
    assign ser_mode    = (function_select == `FUNC_SERIAL);
    assign direct_mode = (function_select >= `FUNC_FTW_FULL) &&
                         (function_select <= `FUNC_LO_POW_LO);
    assign par_write   = par_mode && port_in[`PCTL_WRITE_BIT];
    assign par_read    = par_mode && port_in[`PCTL_READ_BIT];
    assign par_wide    = port_in[`PCTL_WIDE_BIT];
    assign par_index   = port_in[15:10];
    assign par_lane    = port_in[9:8];
    assign stream_en   = control_one_r[`STREAM_ENABLE_BIT];
    assign match_en    = control_two_r[`MATCH_LATENCY_BIT];
    assign osk_en      = control_one_r[`OSK_ENABLE_BIT];
    assign sample_now  = (sample_count_r == `SAMPLE_LAST);

    // ****************************************************************
    // Register file access
    // ****************************************************************
    function [31:0] read_word;
        input [5:0] index;
        begin
            case (index)
                `REG_CONTROL_ONE: read_word = control_one_r;
                `REG_CONTROL_TWO: read_word = control_two_r;
                `REG_FREQ_HOLD:   read_word = freq_hold_r;
                `REG_PHASE_HOLD:  read_word = {16'h0000, phase_hold_r};
                `REG_AMP_HOLD:    read_word = {16'h0000, amp_hold_r};
                `REG_STATUS:      read_word = {23'h000000, sample_count_r,
                                               function_select};
                default:          read_word = 32'h00000000;
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  be;
        integer      k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    merge[k*8 +: 8] = data[k*8 +: 8];
                end
            end
        end
    endfunction

    // Parallel writes act on the rising edge of the write bit, so a host
    // holding the bit for many clocks still makes exactly one write.
    always @* begin
        wr_en    = 1'b0;
        wr_data  = reg_wdata;
        wr_be    = 4'hF;
        wr_index = reg_addr[5:0];
        if (par_write && !prev_write_r) begin
            wr_en    = 1'b1;
            wr_index = par_index;
            if (par_wide) begin
                wr_data = {port_in[31:16], port_in[31:16]};
                wr_be   = par_lane[1] ? 4'hC : 4'h3;
            end else begin
                wr_data = {4{port_in[23:16]}};
                wr_be   = 4'h1 << par_lane;
            end
        end else if (reg_write && (reg_addr[7:6] == 2'b00)) begin
            wr_en = 1'b1;
        end
    end

    // ****************************************************************
    // Holding words: register writes, then direct port loads
    // ****************************************************************
    always @* begin
        control_one_nxt = control_one_r;
        control_two_nxt = control_two_r;
        freq_hold_nxt   = freq_hold_r;
        phase_hold_nxt  = phase_hold_r;
        amp_hold_nxt    = amp_hold_r;
        merge_word      = merge(read_word(wr_index), wr_data, wr_be);
        if (wr_en) begin
            case (wr_index)
                `REG_CONTROL_ONE: control_one_nxt = merge_word;
                `REG_CONTROL_TWO: control_two_nxt = merge_word;
                `REG_FREQ_HOLD:   freq_hold_nxt   = merge_word;
                `REG_PHASE_HOLD:  phase_hold_nxt  = merge_word[15:0];
                `REG_AMP_HOLD:    amp_hold_nxt    = merge_word[15:0];
                default: begin
                end
            endcase
        end
        if (direct_mode && sample_now) begin
            case (function_select)
                `FUNC_FTW_FULL: freq_hold_nxt = port_in;
                `FUNC_FTW_SWAP: freq_hold_nxt = {port_in[15:0],
                                                 port_in[31:16]};
                `FUNC_POW_AMP: begin
                    phase_hold_nxt = port_in[31:16];
                    amp_hold_nxt   = {amp_hold_r[15:12], port_in[11:0]};
                end
                `FUNC_AMP_POW: begin
                    amp_hold_nxt   = {amp_hold_r[15:12], port_in[27:16]};
                    phase_hold_nxt = port_in[15:0];
                end
                default: begin
                    if (function_select <= `FUNC_HI_POW_LO) begin
                        freq_hold_nxt = {port_in[31:8], freq_hold_r[7:0]};
                    end else begin
                        freq_hold_nxt = {freq_hold_r[31:24], port_in[31:8]};
                    end
                    case (function_select[1:0])
                        2'b10: amp_hold_nxt = {port_in[7:0], amp_hold_r[7:0]};
                        2'b11: phase_hold_nxt = {port_in[7:0],
                                                 phase_hold_r[7:0]};
                        2'b00: amp_hold_nxt = {amp_hold_r[15:8], port_in[7:0]};
                        default: phase_hold_nxt = {phase_hold_r[15:8],
                                                   port_in[7:0]};
                    endcase
                end
            endcase
        end
    end

    // ****************************************************************
    // Port drive and serial routing
    // ****************************************************************
    always @* begin
        port_out_nxt = 32'h00000000;
        port_oe_nxt  = 32'h00000000;
        par_word     = read_word(par_index);
        if (par_read && !par_write) begin
            if (par_wide) begin
                port_out_nxt[31:16] = par_lane[1] ? par_word[31:16] :
                                                    par_word[15:0];
                port_oe_nxt[31:16]  = 16'hFFFF;
            end else begin
                port_out_nxt[23:16] = par_word[par_lane*8 +: 8];
                port_oe_nxt[23:16]  = 8'hFF;
            end
        end else if (ser_mode) begin
            // serial lines on the low byte
            port_out_nxt[`SER_SDIO_BIT] = ser_data_io_out;
            port_oe_nxt[`SER_SDIO_BIT]  = ser_data_io_oe;
            port_out_nxt[`SER_SDO_BIT]  = serial_data_out;
            port_oe_nxt[`SER_SDO_BIT]   = serial_data_out_oe;
        end
    end

    // ****************************************************************
    // Sequential state
    // ****************************************************************
    always @(posedge clock) begin
        if (reset) begin
            control_one_r      <= `CONTROL_ONE_RESET;
            control_two_r      <= `CONTROL_TWO_RESET;
            freq_hold_r        <= 32'h00000000;
            phase_hold_r       <= 16'h0000;
            amp_hold_r         <= 16'h0000;
            freq_active_r      <= 32'h00000000;
            phase_active_r     <= 16'h0000;
            amp_active_r       <= 16'h0000;
            sample_count_r     <= 5'h00;
            prev_write_r       <= 1'b0;
            reg_rdata          <= 32'h00000000;
            port_out           <= 32'h00000000;
            port_oe            <= 32'h00000000;
            ser_chip_select_n  <= 1'b1;
            ser_clock          <= 1'b0;
            ser_data_io_in     <= 1'b0;
            serial_port_resync <= 1'b0;
            core_frequency     <= 32'h00000000;
            core_phase         <= 16'h0000;
            core_amplitude     <= 12'h000;
        end else begin
            control_one_r  <= control_one_nxt;
            control_two_r  <= control_two_nxt;
            freq_hold_r    <= freq_hold_nxt;
            phase_hold_r   <= phase_hold_nxt;
            amp_hold_r     <= amp_hold_nxt;
            sample_count_r <= sample_now ? 5'h00 : sample_count_r + 5'h01;
            prev_write_r   <= par_write;
            reg_rdata      <= reg_read ? read_word(reg_addr[5:0]) :
                                         32'h00000000;
            if (reg_addr[7:6] != 2'b00) begin
                reg_rdata <= 32'h00000000;
            end
            port_out <= port_out_nxt;
            port_oe  <= port_oe_nxt;
            // serial inputs taken from the low byte
            ser_chip_select_n  <= ser_mode ? port_in[`SER_CS_BIT] : 1'b1;
            ser_clock          <= ser_mode && port_in[`SER_CLOCK_BIT];
            ser_data_io_in     <= ser_mode && port_in[`SER_SDIO_BIT];
            serial_port_resync <= ser_mode && port_in[`SER_RESYNC_BIT];
            if (stream_en || io_update) begin
                freq_active_r  <= freq_hold_r;
                phase_active_r <= phase_hold_r;
                amp_active_r   <= amp_hold_r;
            end
            core_frequency <= match_en ? freq_long : freq_short;
            core_phase     <= match_en ? phase_long : phase_short;
            core_amplitude <= osk_en ? amp_long[11:0] : `AMP_FULL_SCALE;
        end
    end

    // ****************************************************************
    // Latency paths toward the synthesis core
    // ****************************************************************
    // Amplitude is the slowest path; matching pads the others up to it
    // instead of speeding it up, which costs a few flops per bit.
    param_delay_line #(
        .WIDTH (32),
        .SHORT (`FREQ_LATENCY),
        .LONG  (`AMP_LATENCY)
    ) freq_path (
        .clock      (clock),
        .reset      (reset),
        .data_in    (freq_active_r),
        .data_short (freq_short),
        .data_long  (freq_long)
    );

    param_delay_line #(
        .WIDTH (16),
        .SHORT (`PHASE_LATENCY),
        .LONG  (`AMP_LATENCY)
    ) phase_path (
        .clock      (clock),
        .reset      (reset),
        .data_in    (phase_active_r),
        .data_short (phase_short),
        .data_long  (phase_long)
    );

    param_delay_line #(
        .WIDTH (16),
        .SHORT (`AMP_LATENCY),
        .LONG  (`AMP_LATENCY)
    ) amp_path (
        .clock      (clock),
        .reset      (reset),
        .data_in    (amp_active_r),
        .data_short (),
        .data_long  (amp_long)
    );

endmodule

`default_nettype wire

/* File: src/port_router_defines.vh */
// Constants for the function-pin port router: codes, register map, fields.
`ifndef PORT_ROUTER_DEFINES_VH
`define PORT_ROUTER_DEFINES_VH

// ****************************************************************
// Function-select codes
// ****************************************************************
`define FUNC_PARALLEL      4'h0
`define FUNC_SERIAL        4'h1
`define FUNC_FTW_FULL      4'h2
`define FUNC_FTW_SWAP      4'h3
`define FUNC_POW_AMP       4'h4
`define FUNC_AMP_POW       4'h5
`define FUNC_HI_AMP_HI     4'h6
`define FUNC_HI_POW_HI     4'h7
`define FUNC_HI_AMP_LO     4'h8
`define FUNC_HI_POW_LO     4'h9
`define FUNC_LO_AMP_HI     4'hA
`define FUNC_LO_POW_HI     4'hB
`define FUNC_LO_AMP_LO     4'hC
`define FUNC_LO_POW_LO     4'hD

// ****************************************************************
// Register indices (plain port address) and reset values
// ****************************************************************
`define REG_CONTROL_ONE    6'h00
`define REG_CONTROL_TWO    6'h01
`define REG_FREQ_HOLD      6'h02
`define REG_PHASE_HOLD     6'h03
`define REG_AMP_HOLD       6'h04
`define REG_STATUS         6'h05
`define CONTROL_ONE_RESET  32'h00000000
`define CONTROL_TWO_RESET  32'h00000000

// ****************************************************************
// Field positions
// ****************************************************************
`define OSK_ENABLE_BIT     8
`define STREAM_ENABLE_BIT  17
`define MATCH_LATENCY_BIT  15
`define PCTL_WRITE_BIT     0
`define PCTL_READ_BIT      1
`define PCTL_WIDE_BIT      2
`define SER_CS_BIT         0
`define SER_CLOCK_BIT      1
`define SER_SDIO_BIT       2
`define SER_SDO_BIT        3
`define SER_RESYNC_BIT     4

// ****************************************************************
// Timing counts and amplitude
// ****************************************************************
`define SAMPLE_DIVIDE      5'd24
`define SAMPLE_LAST        5'd23
`define FREQ_LATENCY       1
`define PHASE_LATENCY      2
`define AMP_LATENCY        4
`define AMP_FULL_SCALE     12'hFFF

`endif

/* File: src/param_delay_line.v */
// Delay line with a short tap and a long tap for one synthesis parameter.
`timescale 1ns/1ps
`default_nettype none

module param_delay_line #(
    parameter WIDTH = 32,
    parameter SHORT = 1,
    parameter LONG  = 4
) (
    input  wire             clock,
    input  wire             reset,
    input  wire [WIDTH-1:0] data_in,
    output wire [WIDTH-1:0] data_short,
    output wire [WIDTH-1:0] data_long
);

    reg [WIDTH-1:0] stage_r [0:LONG-1];
    integer         i;

    always @(posedge clock) begin
        if (reset) begin
            for (i = 0; i < LONG; i = i + 1) begin
                stage_r[i] <= {WIDTH{1'b0}};
            end
        end else begin
            stage_r[0] <= data_in;
            for (i = 1; i < LONG; i = i + 1) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    assign data_short = stage_r[SHORT-1];
    assign data_long  = stage_r[LONG-1];

endmodule

`default_nettype wire

/* File: testbench/port_router_monitor.sv */
// Port assertions for the function-pin port router.
`timescale 1ns/1ps
`default_nettype none
module port_router_monitor (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic [3:0]  function_select,
    input wire logic [31:0] port_in,
    input wire logic [31:0] port_out,
    input wire logic [31:0] port_oe,
    input wire logic        serial_data_out,
    input wire logic        serial_data_out_oe,
    input wire logic        ser_data_io_oe,
    input wire logic        ser_chip_select_n,
    input wire logic        ser_clock,
    input wire logic        ser_data_io_in,
    input wire logic        serial_port_resync,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata
);
    // ********
    // Checks
    // ********
    default clocking mon_cb @(posedge clock);
    endclocking
    default disable iff (reset);
    // The edge after reset still shows reset values, so it is skipped.
    a_serial_route: assert property (
        !$past(reset) |-> {serial_port_resync, ser_data_io_in, ser_clock,
        ser_chip_select_n} == ($past(function_select == 4'h1) ?
        $past({port_in[4], port_in[2:0]}) : 4'h1))
        else $error("serial lines misrouted");
    a_sdo_drive: assert property (
        !$past(reset) && $past(function_select == 4'h1) |->
        port_oe[3:2] == $past({serial_data_out_oe, ser_data_io_oe}) &&
        (!port_oe[3] || port_out[3] == $past(serial_data_out)))
        else $error("serial output pins misdriven");
    a_direct_quiet: assert property (
        !$past(reset) && $past(function_select) > 4'h1 &&
        $past(function_select, 2) > 4'h1 |-> port_oe == 32'h0)
        else $error("port driven outside programming modes");
    a_rdata_idle: assert property (
        !$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property (
        $past(reg_read) && $past(reg_addr) > 8'h05 |-> reg_rdata == 32'h0)
        else $error("unmapped register not zero");
    a_status_code: assert property (
        $past(reg_read) && $past(reg_addr) == 8'h05 |->
        reg_rdata[3:0] == $past(function_select))
        else $error("status code differs from pins");
    a_status_bound: assert property (
        $past(reg_read && reg_addr == 8'h05) |-> reg_rdata[8:4] <= 5'h17)
        else $error("sample counter out of range");
    a_sample_stride: assert property (
        reg_read && reg_addr == 8'h05 ##1 reg_read && reg_addr == 8'h05
        |=> reg_rdata[8:4] == ($past(reg_rdata[8:4]) == 5'h17 ? 5'h0 :
        $past(reg_rdata[8:4]) + 5'h1))
        else $error("sample counter stride wrong");
endmodule
`default_nettype wire

/* File: testbench/port_host_model.sv */
// Behavioural host that drives the function pins and the port word.
`timescale 1ns/1ps
`default_nettype none
module port_host_model (
    input  wire logic        clock,
    input  wire logic        start,
    input  wire logic [3:0]  code,
    input  wire logic [31:0] word,
    output var  logic [3:0]  function_select,
    output var  logic [31:0] host_word,
    output var  logic        busy
);
    // ********
    // Transfer
    // ********
    // The hold spans one whole sample period, so one sample edge of the
    // device falls inside it whatever the phase of its divider.
    logic [4:0] count;
    initial begin
        function_select = 4'hE;
        host_word = 32'h0;
        busy = 1'b0;
        count = 5'h0;
    end
    always @(posedge clock) begin
        if (start && !busy) begin
            busy <= 1'b1;
            count <= 5'h0;
            function_select <= 4'hE;
            host_word <= word & 32'hFFFF_FFFE;
        end else if (busy) begin
            count <= count + 5'h1;
            if (count == 5'h0) begin
                function_select <= code;
                host_word <= word;
            end
            if (count == 5'h18) begin
                function_select <= 4'hE;
                host_word <= ~word;
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/test_function_pin_port_router.sv */
// Self-checking bench for the function-pin port router.
`timescale 1ns/1ps
`default_nettype none
module test_function_pin_port_router;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        io_update = 1'b0;
    logic        serial_data_out = 1'b0;
    logic        serial_data_out_oe = 1'b0;
    logic        ser_data_io_out = 1'b0;
    logic        ser_data_io_oe = 1'b0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        start = 1'b0;
    logic [3:0]  code = 4'hE;
    logic [31:0] word = 32'h0;
    logic [31:0] f = 32'h0;
    logic [15:0] p = 16'h0;
    logic [15:0] a = 16'h0;
    logic [3:0]  function_select, serial_pins;
    logic [31:0] host_word, port_in, port_out, port_oe;
    logic [31:0] core_frequency, reg_rdata;
    logic [15:0] core_phase;
    logic [11:0] core_amplitude;
    logic        busy, ser_chip_select_n, ser_clock, ser_data_io_in;
    logic        serial_port_resync;
    int          miscompares = 0;
    int          samples_checked = 0;

    always #20 clock = ~clock;
    // Pins the device drives read back its own level.
    assign port_in = (port_oe & port_out) | (~port_oe & host_word);
    assign serial_pins = {serial_port_resync, ser_data_io_in, ser_clock,
                          ser_chip_select_n};

    function_pin_port_router function_pin_port_router_i (
        .clock(clock), .reset(reset), .function_select(function_select),
        .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
        .io_update(io_update), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe),
        .ser_data_io_out(ser_data_io_out), .ser_data_io_oe(ser_data_io_oe),
        .ser_chip_select_n(ser_chip_select_n), .ser_clock(ser_clock),
        .ser_data_io_in(ser_data_io_in),
        .serial_port_resync(serial_port_resync),
        .core_frequency(core_frequency), .core_phase(core_phase),
        .core_amplitude(core_amplitude), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata));
    port_host_model port_host_model_i (
        .clock(clock), .start(start), .code(code), .word(word),
        .function_select(function_select), .host_word(host_word),
        .busy(busy));

    // ********
    // Tasks
    // ********
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check_core;
        check("core_frequency", f, core_frequency);
        check("core_phase", {16'h0, p}, {16'h0, core_phase});
        check("core_amp", {20'h0, a[11:0]}, {20'h0, core_amplitude});
    endtask
    task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic reg_rd(input logic [7:0] ad, input logic [31:0] exp);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        check("reg_rdata", exp, reg_rdata);
    endtask
    task automatic launch(input logic [3:0] c, input logic [31:0] w);
        code <= c;
        word <= w;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        @(posedge clock);
    endtask
    task automatic settle;
        for (int n = 0; n < 40 && busy; n++)
            @(posedge clock);
        repeat (10) @(posedge clock);
    endtask
    task automatic send(input logic [3:0] c, input logic [31:0] w);
        launch(c, w);
        settle();
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_registers;
        reg_rd(8'h00, 32'h0);
        reg_rd(8'h01, 32'h0);
        reg_wr(8'h40, 32'hFFFF_FFFF);
        reg_rd(8'h00, 32'h0);
        reg_rd(8'h3F, 32'h0);
        reg_wr(8'h00, 32'h0002_0100);
        reg_rd(8'h00, 32'h0002_0100);
        reg_addr <= 8'h05;
        reg_read <= 1'b1;
        repeat (2) @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic t_direct;
        logic [31:0] w;
        logic [3:0]  c;
        for (int i = 2; i < 14; i++) begin
            c = i[3:0];
            w = 32'hC3A5_96E1 ^ {8{c}};
            if (c == 4'h2)
                f = w;
            else if (c == 4'h3)
                f = {w[15:0], w[31:16]};
            else if (c == 4'h4)
                {p, a[11:0]} = {w[31:16], w[11:0]};
            else if (c == 4'h5)
                {a[11:0], p} = {w[27:16], w[15:0]};
            else if (c < 4'hA)
                f[31:8] = w[31:8];
            else
                f[23:0] = w[31:8];
            if (c > 4'h5) begin
                case (c[1:0])
                    2'h2: a[15:8] = w[7:0];
                    2'h3: p[15:8] = w[7:0];
                    2'h0: a[7:0] = w[7:0];
                    default: p[7:0] = w[7:0];
                endcase
            end
            send(c, w);
            check_core();
        end
    endtask
    task automatic t_serial;
        serial_data_out <= 1'b1;
        serial_data_out_oe <= 1'b1;
        ser_data_io_out <= 1'b1;
        ser_data_io_oe <= 1'b1;
        launch(4'h1, 32'hFFFF_FF16);
        repeat (6) @(posedge clock);
        check("serial_pins", 32'hE, {28'h0, serial_pins});
        check("sdo_pin", 32'hC, port_oe & port_out & 32'hF);
        settle();
        check_core();
        send(4'hF, 32'h1234_5678);
        check_core();
    endtask
    task automatic t_osk;
        reg_wr(8'h00, 32'h0002_0000);
        repeat (8) @(posedge clock);
        check("core_amp", 32'hFFF, {20'h0, core_amplitude});
        reg_wr(8'h00, 32'h0000_0100);
    endtask
    task automatic t_strobe;
        send(4'h2, 32'h0F1E_2D3C);
        check("core_frequency", f, core_frequency);
        reg_rd(8'h02, 32'h0F1E_2D3C);
        io_update <= 1'b1;
        @(posedge clock);
        io_update <= 1'b0;
        f = 32'h0F1E_2D3C;
        repeat (8) @(posedge clock);
        check_core();
        reg_wr(8'h00, 32'h0002_0100);
    endtask
    task automatic t_parallel;
        send(4'h0, 32'hABCD_0805);
        reg_rd(8'h02, {f[31:16], 16'hABCD});
        send(4'h0, 32'h005A_0B01);
        reg_rd(8'h02, {8'h5A, f[23:16], 16'hABCD});
        launch(4'h0, 32'h0000_0806);
        repeat (6) @(posedge clock);
        check("read_drive", 32'hABCD_FFFF, {port_out[31:16], port_oe[31:16]});
        settle();
    endtask
    task automatic t_match;
        reg_wr(8'h01, 32'h0000_8000);
        f = 32'h1357_9BCD;
        a[15:8] = 8'hC7;
        launch(4'h6, 32'h1357_9BC7);
        for (int n = 0; n < 60 && core_frequency !== f; n++)
            @(posedge clock);
        check_core();
    endtask

    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_registers();
        t_direct();
        t_serial();
        t_osk();
        t_strobe();
        t_parallel();
        t_match();
        final_report();
    end
    // The run needs under 1500 cycles; this bound cuts a hang short.
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        final_report();
    end
endmodule

bind function_pin_port_router port_router_monitor port_router_monitor_i (
    .clock(clock), .reset(reset), .function_select(function_select),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe),
    .ser_data_io_oe(ser_data_io_oe),
    .ser_chip_select_n(ser_chip_select_n), .ser_clock(ser_clock),
    .ser_data_io_in(ser_data_io_in),
    .serial_port_resync(serial_port_resync), .reg_addr(reg_addr),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
`default_nettype wire
